// ### rtl/serial_port.v
// Behaviour
// - Separate 16-deep half-word RX and TX FIFOs behind one data port.
// - RX irq at RX half full, TX irq at TX half empty.
// - Slave: clock, rx data and both syncs are inputs; tx data out.
// - Master: clock, tx data and both syncs are driven outputs.
// - Control-two bit 9 high selects master, low selects slave.
// - Bits 4 and 7 enable TX and RX halves; both clear is off.
// - Each byte has a one-clock sync one clock before its first bit.
// - Bits travel most significant first only.
// - Master clock rate from control-one bits 17:16: 4,16,64,128 kHz.
// - Enables take effect and read back one serial clock after write; an idle master takes them within two clocks, a slave drops both at once.
// - TX takes half-words; RX bytes load in pairs, odd byte is residual.
// - Residual sets both flags; valid clears on read or new byte.
// - Writing the pop location pushes the residual byte into RX FIFO.
// - FIFO accesses are words; only lower 16 bits carry data.
// - RX byte follows RX sync, TX byte follows TX sync, independent.
// - Back-to-back syncs repeat every eight clocks, aligned with D0.
// - As master the serial clock runs continuously while TX or RX is enabled.
// - RX overflow sets overrun flag; write to clear location clears.
// - TX underflow sets flag; a TX FIFO write clears it.
// - Slave mode works with external clocks up to 512 kHz.
// - Launch on rising, capture on falling; tx data off when idle.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.vh"
module serial_port (
  input wire clk_i,
  input wire resetn_i,
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire port_serial_clock_pin_i,
  output reg port_serial_clock_pin_o,
  output reg port_serial_clock_pin_oe_o,
  input wire port_rx_data_pin_i,
  output reg port_tx_data_pin_o,
  output reg port_tx_data_pin_oe_o,
  input wire rx_frame_sync_pin_i,
  output reg rx_frame_sync_pin_o,
  output reg rx_frame_sync_pin_oe_o,
  input wire tx_frame_sync_pin_i,
  output reg tx_frame_sync_pin_o,
  output reg tx_frame_sync_pin_oe_o,
  output reg rx_half_full_irq_o,
  output reg tx_half_empty_irq_o
);
  // ----------------------------------------------------------------------
  // Synchronisers for the pins; the first stage feeds only the second.
  // ----------------------------------------------------------------------
  reg [3:0] meta_q;
  reg [3:0] sync_q;
  reg sclk_prev_q;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      sclk_prev_q <= 1'b0;
    end else begin
      meta_q <= {tx_frame_sync_pin_i, rx_frame_sync_pin_i,
                 port_rx_data_pin_i, port_serial_clock_pin_i};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[0];
    end
  end

  // ----------------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------------
  reg [1:0] rate_q;
  reg master_q;
  reg txen_req_q;
  reg rxen_req_q;
  reg txen_q;
  reg rxen_q;
  reg ovr_q;
  reg und_q;
  reg residual_valid_flag_q;
  reg residual_frame_flag_q;
  reg [7:0] res_byte_q;
  reg [15:0] mcnt_q;
  reg mclk_q;
  wire master_w = master_q;
  wire ser_clk = master_w ? mclk_q : sync_q[0];
  wire ser_prev = master_w ? port_serial_clock_pin_o : sclk_prev_q;
  wire ser_rise = ser_clk & ~ser_prev;
  wire ser_fall = ~ser_clk & ser_prev;

  // Half period count selected by the rate field.
  function [31:0] half_of;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: half_of = `HALF0;
        2'b01: half_of = `HALF1;
        2'b10: half_of = `HALF2;
        default: half_of = `HALF3;
      endcase
    end
  endfunction

  // Master clock divider; never stops between bytes so the link has a
  // steady clock to frame against.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mcnt_q <= 16'h0000;
      mclk_q <= 1'b0;
    end else if (!master_w || !(txen_q || rxen_q)) begin
      mcnt_q <= 16'h0000;
      mclk_q <= 1'b0;
    end else if ({16'h0000, mcnt_q} >= half_of(rate_q) - 32'h1) begin
      mcnt_q <= 16'h0000;
      mclk_q <= ~mclk_q;
    end else begin
      mcnt_q <= mcnt_q + 16'h0001;
    end
  end

  // Requested enables move into force on a serial rising edge, or at once for a slave with none requested; a master with
  // none in force takes them two clocks after the request, so its divider can start up.
  wire any_req = txen_req_q | rxen_req_q;
  reg gate_q;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txen_q <= 1'b0;
      rxen_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      gate_q <= any_req;
      if (ser_rise || (!any_req && !master_w)) begin
        txen_q <= txen_req_q;
        rxen_q <= rxen_req_q;
      end else if (master_w && any_req && !(txen_q || rxen_q)) begin
        txen_q <= txen_req_q & gate_q;
        rxen_q <= rxen_req_q & gate_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // FIFOs: flip-flop storage indexed by pointers, one per direction.
  // ----------------------------------------------------------------------
  reg [15:0] txmem_q [0:`FIFO_DEPTH-1];
  reg [15:0] rxmem_q [0:`FIFO_DEPTH-1];
  reg [3:0] txwp_q, txrp_q, rxwp_q, rxrp_q;
  reg [4:0] txcnt_q, rxcnt_q;
  wire is_wr = avs_write_i & ~avs_waitrequest_o;
  wire is_rd = avs_read_i & ~avs_waitrequest_o;
  wire tx_push = is_wr && avs_address_i == `DATA_PORT_ADDR &&
                 txcnt_q != `FIFO_DEPTH;
  wire rx_pop = is_rd && avs_address_i == `DATA_PORT_ADDR &&
                rxcnt_q != 5'h00;
  reg tx_pop;
  reg rx_push;
  reg [15:0] rx_push_data;
  wire pop_wr = is_wr && avs_address_i == `POP_ADDR;

  always @(posedge clk_i) begin
    if (tx_push)
      txmem_q[txwp_q] <= avs_writedata_i[15:0];
    if (rx_push && rxcnt_q != `FIFO_DEPTH)
      rxmem_q[rxwp_q] <= rx_push_data;
  end

  // Pointers and counts of both FIFOs.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txwp_q <= 4'h0;
      txrp_q <= 4'h0;
      rxwp_q <= 4'h0;
      rxrp_q <= 4'h0;
      txcnt_q <= 5'h00;
      rxcnt_q <= 5'h00;
    end else begin
      if (tx_push)
        txwp_q <= txwp_q + 4'h1;
      if (tx_pop)
        txrp_q <= txrp_q + 4'h1;
      txcnt_q <= txcnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
      if (rx_push && rxcnt_q != `FIFO_DEPTH)
        rxwp_q <= rxwp_q + 4'h1;
      if (rx_pop)
        rxrp_q <= rxrp_q + 4'h1;
      rxcnt_q <= rxcnt_q + {4'h0, rx_push && rxcnt_q != `FIFO_DEPTH} -
                 {4'h0, rx_pop};
    end
  end

  // ----------------------------------------------------------------------
  // Transmit side: sync one clock ahead of the MSB, then 8 bits.
  // ----------------------------------------------------------------------
  reg [15:0] txword_q;
  reg txhalf_q;
  reg txhave_q;
  reg [7:0] txsh_q;
  reg [3:0] txbit_q;
  reg txsync_q;
  reg [2:0] mtx_q;
  wire tx_sync_now = sync_q[3]; // Registered in txsync_q so the MSB follows the sync.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txword_q <= 16'h0000;
      txhalf_q <= 1'b0;
      txhave_q <= 1'b0;
      txsh_q <= 8'h00;
      txbit_q <= 4'h0;
      txsync_q <= 1'b0;
      mtx_q <= 3'h0;
      tx_pop <= 1'b0;
      und_q <= 1'b0;
    end else begin
      tx_pop <= 1'b0;
      if (tx_push)
        und_q <= 1'b0;
      if (!txen_q) begin
        txbit_q <= 4'h0;
        txsync_q <= 1'b0;
        mtx_q <= 3'h0;
      end else if (ser_rise) begin
        mtx_q <= mtx_q + 3'h1;
        txsync_q <= master_w ? (mtx_q == 3'h6) : tx_sync_now;
        if (txbit_q != 4'h0) begin
          txsh_q <= {txsh_q[6:0], 1'b0};
          txbit_q <= txbit_q - 4'h1;
        end
        if (txsync_q) begin
          txbit_q <= 4'h8;
          if (txhave_q && txhalf_q) begin
            txsh_q <= txword_q[7:0];
            txhave_q <= 1'b0;
          end else if (txcnt_q != 5'h00 && !tx_pop) begin
            txsh_q <= txmem_q[txrp_q][15:8];
            txword_q <= txmem_q[txrp_q];
            txhave_q <= 1'b1;
            txhalf_q <= 1'b1;
            tx_pop <= 1'b1;
          end else begin
            txsh_q <= 8'h00;
            und_q <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive side: capture on falling edges, pair bytes into half-words.
  // ----------------------------------------------------------------------
  reg [7:0] rxsh_q;
  reg [3:0] rxbit_q;
  reg rxarm_q;
  reg [2:0] mrx_q;
  reg rxsync_q;
  wire rx_sync_now = master_w ? rxsync_q : sync_q[2];
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rxsh_q <= 8'h00;
      rxbit_q <= 4'h0;
      rxarm_q <= 1'b0;
      mrx_q <= 3'h0;
      rxsync_q <= 1'b0;
      rx_push <= 1'b0;
      rx_push_data <= 16'h0000;
      residual_valid_flag_q <= 1'b0;
      residual_frame_flag_q <= 1'b0;
      res_byte_q <= 8'h00;
      ovr_q <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (ser_rise && rxen_q) begin
        mrx_q <= mrx_q + 3'h1;
        rxsync_q <= master_w && mrx_q == 3'h6;
      end
      if (is_wr && avs_address_i == `OVR_CLR_ADDR)
        ovr_q <= 1'b0;
      if (is_rd && avs_address_i == `FLAGS_TWO_ADDR && residual_valid_flag_q)
        residual_valid_flag_q <= 1'b0;
      if (pop_wr) begin
        rx_push <= 1'b1;
        rx_push_data <= {8'h00, res_byte_q};
        residual_valid_flag_q <= 1'b0;
      end
      if (!rxen_q) begin
        rxbit_q <= 4'h0;
        rxarm_q <= 1'b0;
        mrx_q <= 3'h0;
        rxsync_q <= 1'b0;
      end else if (ser_fall) begin
        if (rx_sync_now && rxbit_q == 4'h0) begin
          rxbit_q <= 4'h8;
        end else if (rxbit_q != 4'h0) begin
          rxsh_q <= {rxsh_q[6:0], sync_q[1]};
          rxbit_q <= rxbit_q - 4'h1;
          if (rxbit_q == 4'h1) begin
            residual_valid_flag_q <= 1'b0;
            residual_frame_flag_q <= 1'b0;
            if (rxarm_q) begin
              rx_push <= 1'b1;
              rx_push_data <= {res_byte_q, rxsh_q[6:0], sync_q[1]};
              rxarm_q <= 1'b0;
            end else begin
              res_byte_q <= {rxsh_q[6:0], sync_q[1]};
              rxarm_q <= 1'b1;
            end
          end
          if (rxbit_q == 4'h1 && rx_sync_now)
            rxbit_q <= 4'h8;
        end
      end else if (rxarm_q && rxbit_q == 4'h0 && ser_rise && !rx_sync_now) begin
        residual_valid_flag_q <= 1'b1;
        residual_frame_flag_q <= 1'b1;
        rxarm_q <= 1'b0;
      end
      if (rx_push && rxcnt_q == `FIFO_DEPTH)
        ovr_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Avalon slave: one wait state, then answer.
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      rate_q <= 2'b00;
      master_q <= 1'b0;
      txen_req_q <= 1'b0;
      rxen_req_q <= 1'b0;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (is_wr && avs_address_i == `CTRL_ONE_ADDR && avs_byteenable_i[2])
        rate_q <= avs_writedata_i[`RATE_LO+1:`RATE_LO];
      if (is_wr && avs_address_i == `CTRL_TWO_ADDR) begin
        if (avs_byteenable_i[1])
          master_q <= avs_writedata_i[`MASTER_BIT];
        if (avs_byteenable_i[0]) begin
          txen_req_q <= avs_writedata_i[`TXEN_BIT];
          rxen_req_q <= avs_writedata_i[`RXEN_BIT];
        end
      end
      if (!(avs_read_i & avs_waitrequest_o))
        avs_readdata_o <= 32'h0000_0000;
      else begin
        case (avs_address_i)
          `CTRL_ONE_ADDR: avs_readdata_o <= {14'h0000, rate_q, 16'h0000};
          `CTRL_TWO_ADDR: avs_readdata_o <= {22'h000000, master_q, 1'b0,
                                             rxen_q, 2'b00, txen_q,
                                             4'h0};
          `FLAGS_TWO_ADDR: avs_readdata_o <= {24'h000000,
                                              txcnt_q == `FIFO_DEPTH,
                                              rxcnt_q == 5'h00,
                                              tx_half_empty_irq_o,
                                              rx_half_full_irq_o,
                                              residual_frame_flag_q, residual_valid_flag_q,
                                              und_q, ovr_q};
          `DATA_PORT_ADDR: avs_readdata_o <= {16'h0000, rxmem_q[rxrp_q]};
          default: avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive and interrupts, all from flip-flops.
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_serial_clock_pin_o <= 1'b0;
      port_serial_clock_pin_oe_o <= 1'b0;
      port_tx_data_pin_o <= 1'b0;
      port_tx_data_pin_oe_o <= 1'b0;
      rx_frame_sync_pin_o <= 1'b0;
      rx_frame_sync_pin_oe_o <= 1'b0;
      tx_frame_sync_pin_o <= 1'b0;
      tx_frame_sync_pin_oe_o <= 1'b0;
      rx_half_full_irq_o <= 1'b0;
      tx_half_empty_irq_o <= 1'b0;
    end else begin
      port_serial_clock_pin_o <= mclk_q;
      port_serial_clock_pin_oe_o <= master_w;
      rx_frame_sync_pin_oe_o <= master_w;
      tx_frame_sync_pin_oe_o <= master_w;
      tx_frame_sync_pin_o <= txsync_q;
      rx_frame_sync_pin_o <= rxsync_q;
      port_tx_data_pin_o <= txsh_q[7];
      port_tx_data_pin_oe_o <= txen_q && txbit_q != 4'h0;
      rx_half_full_irq_o <= rxen_q && rxcnt_q >= `FIFO_HALF;
      tx_half_empty_irq_o <= txen_q && txcnt_q <= `FIFO_HALF;
    end
  end
endmodule // serial_port
`default_nettype wire

// ### rtl/ssp_regs.vh
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
// ----------------------------------------------------------------------
// Register map (byte addresses, word aligned).
// ----------------------------------------------------------------------
`define CTRL_ONE_ADDR 5'h00
`define CTRL_TWO_ADDR 5'h04
`define FLAGS_TWO_ADDR 5'h08
`define DATA_PORT_ADDR 5'h0c
`define POP_ADDR 5'h10
`define OVR_CLR_ADDR 5'h14
// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define RATE_LO 16
`define TXEN_BIT 4
`define RXEN_BIT 7
`define MASTER_BIT 9
`define FLG_OVR 0
`define FLG_UND 1
`define FLG_RESIDUAL_VALID_FLAG 2
`define FLG_RESIDUAL_FRAME_FLAG 3
`define FLG_RXHF 4
`define FLG_TXHE 5
`define FLG_RXEMPTY 6
`define FLG_TXFULL 7
// ----------------------------------------------------------------------
// Reset values and sizes.
// ----------------------------------------------------------------------
`define CTRL_ONE_RST 32'h0000_0000
`define CTRL_TWO_RST 32'h0000_0000
`define FIFO_DEPTH 16
`define FIFO_HALF 8
// ----------------------------------------------------------------------
// Timing: half periods of the master serial clock at 125 MHz.
// ----------------------------------------------------------------------
`define CLK_HZ 125000000
`define RATE0_HZ 4000
`define RATE1_HZ 16000
`define RATE2_HZ 64000
`define RATE3_HZ 128000
`define HALF0 (`CLK_HZ / (2 * `RATE0_HZ))
`define HALF1 (`CLK_HZ / (2 * `RATE1_HZ))
`define HALF2 (`CLK_HZ / (2 * `RATE2_HZ))
`define HALF3 (`CLK_HZ / (2 * `RATE3_HZ))
`endif

// ### testbench/serial_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic port_serial_clock_pin_o,
  input wire logic port_serial_clock_pin_oe_o,
  input wire logic port_tx_data_pin_o,
  input wire logic port_tx_data_pin_oe_o,
  input wire logic tx_frame_sync_pin_o,
  input wire logic tx_frame_sync_pin_oe_o,
  input wire logic rx_frame_sync_pin_oe_o,
  input wire logic rx_half_full_irq_o,
  input wire logic tx_half_empty_irq_o
);
  // --------
  // Serial clock history
  // --------
  logic sck_q;
  logic sck_qq;
  logic seen_q;
  int unsigned half_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // The first half period after the master starts is skipped, because the
  // count then still holds idle time from slave mode.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_q <= 1'b0;
      sck_qq <= 1'b0;
      seen_q <= 1'b0;
      half_q <= 0;
    end else begin
      sck_q <= port_serial_clock_pin_o;
      sck_qq <= sck_q;
      half_q <= (port_serial_clock_pin_o != sck_q) ? 1 : half_q + 1;
      seen_q <= port_serial_clock_pin_oe_o &&
                (seen_q || port_serial_clock_pin_o != sck_q);
    end
  end
  wire rise_w = port_serial_clock_pin_o & ~sck_q;
  wire rise_prev_w = sck_q & ~sck_qq;
  wire sck_edge_w = port_serial_clock_pin_o != sck_q;
  wire half_ok_w = half_q inside {[487:489], [975:977], [3905:3907],
                                  [15624:15626]};
  // --------
  // Assertions
  // --------
  chk_wait_short: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:2]
    !avs_waitrequest_o) else $error("bus answer is late");
  chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("bus answer stands too long");
  chk_wait_idle: assert property (
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("bus answer without request");
  chk_oe_group: assert property (
    port_serial_clock_pin_oe_o == tx_frame_sync_pin_oe_o &&
    port_serial_clock_pin_oe_o == rx_frame_sync_pin_oe_o)
    else $error("pin directions disagree");
  chk_clk_runs: assert property (
    port_serial_clock_pin_oe_o && seen_q |-> half_q <= 15626)
    else $error("master serial clock stopped");
  chk_half_rate: assert property (
    seen_q && sck_edge_w |-> half_ok_w)
    else $error("master half period off rate");
  chk_txd_launch: assert property (
    port_serial_clock_pin_oe_o && port_tx_data_pin_oe_o &&
    $changed(port_tx_data_pin_o) |-> rise_w || rise_prev_w)
    else $error("tx data moved away from rising clock");
  chk_sync_launch: assert property (
    tx_frame_sync_pin_oe_o && $changed(tx_frame_sync_pin_o) |->
    rise_w || rise_prev_w) else $error("tx sync moved off rising clock");
  chk_reset_quiet: assert property (
    $rose(resetn_i) |-> !rx_half_full_irq_o && !tx_half_empty_irq_o &&
    !port_serial_clock_pin_oe_o && !port_tx_data_pin_oe_o)
    else $error("outputs active after reset");
  cover property (seen_q && rise_w);
  cover property (port_tx_data_pin_oe_o);
  cover property (rx_half_full_irq_o);
endmodule // serial_port_chk
bind serial_port serial_port_chk u_chk (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .port_serial_clock_pin_o(port_serial_clock_pin_o),
  .port_serial_clock_pin_oe_o(port_serial_clock_pin_oe_o),
  .port_tx_data_pin_o(port_tx_data_pin_o),
  .port_tx_data_pin_oe_o(port_tx_data_pin_oe_o),
  .tx_frame_sync_pin_o(tx_frame_sync_pin_o),
  .tx_frame_sync_pin_oe_o(tx_frame_sync_pin_oe_o),
  .rx_frame_sync_pin_oe_o(rx_frame_sync_pin_oe_o),
  .rx_half_full_irq_o(rx_half_full_irq_o),
  .tx_half_empty_irq_o(tx_half_empty_irq_o)
);
`default_nettype wire

// ### testbench/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic txd_i,
  output logic sck_o,
  output logic rxd_o,
  output logic rxfs_o,
  output logic txfs_o
);
  logic [7:0] to_dut [$];
  logic [7:0] got [$];
  logic [7:0] sh;
  // The link idles with its clock parked low.
  initial begin
    sck_o = 1'b0;
    rxd_o = 1'b0;
    rxfs_o = 1'b0;
    txfs_o = 1'b0;
    sh = 8'h00;
  end
  // One 64 ns serial clock: launch on the rising edge, sample late in the
  // low phase so the block's synchroniser delay does not eat the margin.
  task automatic tick(input logic fs, input logic d, input logic cap);
    sck_o = 1'b1;
    rxfs_o = fs;
    txfs_o = fs;
    rxd_o = d;
    #32 sck_o = 1'b0;
    #28 if (cap) sh = {sh[6:0], txd_i};
    #4;
  endtask
  // A frame of n bytes sent back to back, a sync one clock ahead of the first byte and in each D0 clock but the last.
  task automatic frame(input int n);
    got.delete();
    #3;
    tick(1'b0, ~rxd_o, 1'b0);
    tick(1'b0, ~rxd_o, 1'b0);
    for (int c = 0; c <= 8 * n; c++) begin
      tick(c % 8 == 0 && c < 8 * n,
           (c == 0) ? ~rxd_o : to_dut[(c - 1) / 8][7 - (c - 1) % 8],
           c > 0);
      if (c > 0 && c % 8 == 0) got.push_back(sh);
    end
    tick(1'b0, ~rxd_o, 1'b0);
    rxd_o = ~rxd_o;
    to_dut.delete();
  endtask
endmodule // serial_peer
`default_nettype wire

// ### testbench/serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.vh"
module serial_port_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] q;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, sck_o, sck_oe, txd_o, txd_oe, rx_irq, tx_irq;
  wire rxfs_o, rxfs_oe, txfs_o, txfs_oe, p_sck, p_rxd, p_rxfs, p_txfs;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  // Shared pins settle to whichever side drives them.
  wire sck_w = sck_oe ? sck_o : p_sck;
  wire rxfs_w = rxfs_oe ? rxfs_o : p_rxfs;
  wire txfs_w = txfs_oe ? txfs_o : p_txfs;
  wire txd_w = txd_oe ? txd_o : 1'bz;
  always #4 clk_i = ~clk_i;
  serial_port DUT (.clk_i(clk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .port_serial_clock_pin_i(sck_w), .port_serial_clock_pin_o(sck_o),
    .port_serial_clock_pin_oe_o(sck_oe), .port_rx_data_pin_i(p_rxd),
    .port_tx_data_pin_o(txd_o), .port_tx_data_pin_oe_o(txd_oe),
    .rx_frame_sync_pin_i(rxfs_w), .rx_frame_sync_pin_o(rxfs_o),
    .rx_frame_sync_pin_oe_o(rxfs_oe), .tx_frame_sync_pin_i(txfs_w),
    .tx_frame_sync_pin_o(txfs_o), .tx_frame_sync_pin_oe_o(txfs_oe),
    .rx_half_full_irq_o(rx_irq), .tx_half_empty_irq_o(tx_irq));
  serial_peer peer (.txd_i(txd_w), .sck_o(p_sck), .rxd_o(p_rxd),
    .rxfs_o(p_rxfs), .txfs_o(p_txfs));
  // --------
  // Checking and bus tasks
  // --------
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The request is held until waitrequest is sampled low, never assumed.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (k >= 50) chk("bus answer", 32'h1, 32'h0);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q & m, e);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400_000;
    error_cnt++;
    stop_test();
  end
  // --------
  // Tests
  // --------
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`CTRL_ONE_ADDR, 32'hffff_ffff, `CTRL_ONE_RST, "ctrl one");
    rd(`CTRL_TWO_ADDR, 32'hffff_ffff, `CTRL_TWO_RST, "ctrl two");
    rd(`FLAGS_TWO_ADDR, 32'hc0, 32'h40, "fifos empty");
    rd(5'h1c, 32'hffff_ffff, 32'h0, "unmapped");
    $display("test reset done");
    bus(1'b1, `CTRL_TWO_ADDR, 32'h90);
    rd(`CTRL_TWO_ADDR, 32'hffff_ffff, 32'h0, "enable early");
    peer.frame(0);
    rd(`CTRL_TWO_ADDR, 32'hffff_ffff, 32'h90, "enable late");
    @(negedge clk_i);
    chk("tx irq empty", {31'h0, tx_irq}, 32'h1);
    $display("test enable done");
    peer.to_dut = '{8'h12, 8'h34, 8'h56};
    peer.frame(3);
    for (int i = 0; i < 3; i++) chk("underrun byte", {24'h0, peer.got[i]}, 0);
    rd(`FLAGS_TWO_ADDR, 32'h0e, 32'h0e, "residual set");
    bus(1'b1, `POP_ADDR, 32'hdead_beef);
    rd(`FLAGS_TWO_ADDR, 32'h0c, 32'h08, "residual popped");
    rd(`DATA_PORT_ADDR, 32'hffff, 32'h1234, "rx pair");
    rd(`DATA_PORT_ADDR, 32'hffff, 32'h0056, "rx residual");
    bus(1'b1, `DATA_PORT_ADDR, 32'hffff_a55a);
    rd(`FLAGS_TWO_ADDR, 32'h02, 32'h0, "underrun clear");
    $display("test residual done");
    peer.to_dut = '{8'h81, 8'h7e};
    peer.frame(2);
    chk("tx first byte", {24'h0, peer.got[0]}, 32'ha5);
    chk("tx second byte", {24'h0, peer.got[1]}, 32'h5a);
    rd(`DATA_PORT_ADDR, 32'hffff_ffff, 32'h817e, "rx word");
    rd(`FLAGS_TWO_ADDR, 32'h0c, 32'h0, "residual gone");
    $display("test transfer done");
    for (int i = 0; i < 34; i++) peer.to_dut.push_back(i[7:0]);
    peer.frame(34);
    @(negedge clk_i);
    chk("rx irq", {31'h0, rx_irq}, 32'h1);
    rd(`FLAGS_TWO_ADDR, 32'h01, 32'h01, "overrun set");
    bus(1'b1, `OVR_CLR_ADDR, 32'h0);
    rd(`FLAGS_TWO_ADDR, 32'h01, 32'h0, "overrun clear");
    for (int i = 0; i < 16; i++) rd(`DATA_PORT_ADDR, 32'hffff, 32'((2 * i) << 8 | (2 * i + 1)), "rx fill");
    rd(`FLAGS_TWO_ADDR, 32'h40, 32'h40, "rx drained");
    $display("test overrun done");
    for (int i = 0; i < 16; i++) bus(1'b1, `DATA_PORT_ADDR, 32'(i));
    rd(`FLAGS_TWO_ADDR, 32'h80, 32'h80, "tx full");
    @(negedge clk_i);
    chk("tx irq full", {31'h0, tx_irq}, 32'h0);
    $display("test tx fill done");
    bus(1'b1, `CTRL_ONE_ADDR, 32'h0003_0000);
    rd(`CTRL_ONE_ADDR, 32'hffff_ffff, 32'h0003_0000, "rate");
    bus(1'b1, `CTRL_TWO_ADDR, 32'h290);
    n = 0;
    while (sck_oe !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    @(negedge clk_i);
    chk("master clock drive", {31'h0, sck_oe}, 32'h1);
    chk("master sync drive", {31'h0, txfs_oe}, 32'h1);
    // Long enough for the checker to watch some twenty serial clocks.
    repeat (20000) @(posedge clk_i);
    rd(`CTRL_TWO_ADDR, 32'hffff_ffff, 32'h290, "master mode");
    bus(1'b1, `CTRL_TWO_ADDR, 32'h0);
    repeat (3000) @(posedge clk_i);
    chk("slave clock free", {31'h0, sck_oe}, 32'h0);
    chk("slave sync free", {31'h0, rxfs_oe}, 32'h0);
    rd(`CTRL_TWO_ADDR, 32'hffff_ffff, 32'h0, "port off");
    $display("test master done");
    stop_test();
  end
endmodule // serial_port_tb
`default_nettype wire
